// ==== logic/sao_map.svh ====
// Constants: offsets, field positions, patterns, reset values and counts
`ifndef SAO_MAP_SVH
`define SAO_MAP_SVH
`define SAO_CELLS_LAST   7'h7f
`define SAO_CELL_ONE     7'h01
`define SAO_SUB_START    6'h00
`define SAO_FRAMES_LAST  8'hbf
`define SAO_FRAME_FIRST  8'h00
`define SAO_FRAME_ONE    8'h01
`define SAO_PRE_B        8'he8
`define SAO_PRE_W        8'he4
`define SAO_PRE_M        8'he2
`define SAO_PRE_SLOTS    5'h04
`define SAO_SLOT_AUD     5'h04
`define SAO_SLOT_AUD_END 5'h1b
`define SAO_SLOT_V       5'h1c
`define SAO_SLOT_U       5'h1d
`define SAO_SLOT_C       5'h1e
`define SAO_SLOT_P       5'h1f
`define SAO_I2S_BITS     5'h18
`define SAO_I2S_ONE      6'h01
`define SAO_WS_RISE      6'h1f
`define SAO_WS_FALL      6'h3f
`define SAO_SCK_FRAME    7'h40
`define SAO_CS_COPY      8'h02
`define SAO_CS_FS_LO     8'h18
`define SAO_CS_FS_HI     8'h1b
`define SAO_FS_CODE_48   4'h4
`define SAO_FS_CODE_44   4'h0
`define SAO_FS_CODE_32   4'hc
`define SAO_USER_BITS    4'h9
`define SAO_USER_ONE     4'h1
`define SAO_V_RST        1'b0
`define SAO_COPY_RST     1'b1
`define SAO_RND_MASK16   24'hffff00
`define SAO_RND_HALF16   24'h000080
`define SAO_RND_MASK18   24'hffffc0
`define SAO_RND_HALF18   24'h000020
`define SAO_RND_MASK20   24'hfffff0
`define SAO_RND_HALF20   24'h000008
`define SAO_RND_MASK22   24'hfffffc
`define SAO_RND_HALF22   24'h000002
`define SAO_SAT_POS      24'h7fffff
`define SAO_FIFO_DEPTH   2'h2
`endif

// ==== logic/sao_pkg.sv ====
// Types shared by the audio output serializer
package sao_pkg;
    typedef enum logic [2:0] {FS_48, FS_44, FS_32, FS_24, FS_22, FS_16} sao_fs_t;
    typedef enum logic [1:0] {RND_16, RND_18, RND_20, RND_22} sao_rnd_t;
    typedef logic [23:0] sao_sample_t;
endpackage : sao_pkg

// ==== logic/sao_pair_fifo.sv ====
// Two-entry buffer for stereo sample pairs
`include "sao_map.svh"
module sao_pair_fifo (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic [47:0] in_data_i,
    input  wire logic        in_valid_i,
    output logic             in_ready_o,
    output logic [47:0]      out_data_o,
    output logic             out_valid_o,
    input  wire logic        out_ready_i
);
    logic [47:0] mem_q [0:1];
    logic        wr_q;
    logic        rd_q;
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    logic        rdy_q;
    wire         push = in_valid_i & rdy_q;
    wire         pop  = out_ready_i & out_valid_o;

    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];
    assign in_ready_o  = rdy_q;
    assign cnt_d = (push && !pop) ? cnt_q + 2'h1 :
                   (pop && !push) ? cnt_q - 2'h1 : cnt_q;

    always_ff @(posedge clk_i)
    begin
        if (ce_i && push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
            rdy_q <= 1'b1;
        end
        else if (ce_i)
        begin
            wr_q  <= wr_q ^ push;
            rd_q  <= rd_q ^ pop;
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != `SAO_FIFO_DEPTH);
        end
    end
endmodule : sao_pair_fifo

// ==== logic/sao_serializer.sv ====
// Stereo audio output serializer: inter-IC sound link and bi-phase digital audio link
//
// Functional notes
// [RL1] Serial bit clock runs at 64 times the sample rate.
// [RL2] Left sample goes first, right follows; together one stereo pair.
// [RL3] Each channel slot is 32 bits, two's complement, MSB first.
// [RL4] Samples rounded to 16/18/20/22 bits by two select bits; rest zero.
// [RL5] Word select low for left bits, high for right bits.
// [RL6] One digital frame per sample period, two 32-slot subframes.
// [RL7] Subframe bits 4 to 31 use bi-phase mark coding.
// [RL8] Slots 0 to 3 carry raw 8-cell preamble B, W or M.
// [RL9] B starts each 192-frame block; M other left, W every right.
// [RL10] Audio in bits 4 to 27, LSB first, low bits zeroed by rounding.
// [RL11] Bit 28 carries validity setting, zero after reset.
// [RL12] User byte sent at once in bit 29: start bit, 8 bits LSB first.
// [RL13] Host spaces user bytes so nine zeros lie between messages.
// [RL14] One 192-bit status block per channel, bit 30, bit 0 first.
// [RL15] Status bits 0,1,3-23 except bit 2 are zero.
// [RL16] Status bit 2 is copy flag, one after reset.
// [RL17] Status bits 24-27 follow sample rate: 48k, 44.1k, 32k codes.
// [RL18] Low sample rates send a host-set code in bits 24-27.
// [RL19] Status bits 28-29 zero and all remaining bits zero.
// [RL20] Bit 31 makes bits 4 to 31 even parity.
// [RL21] Frames run back to back, never partial.
// [RL22] Each link enabled separately; a disabled link stays quiet.
// [RL23] Mono or selected dual channel appears on both outputs.
// [RL24] Word select changes one bit before the slot MSB; the code changes it two bits before.
// [RL25] Both links use one sample register updated once per period.
`include "sao_map.svh"
module sao_serializer (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        cell_clk_i,
    input  wire logic [23:0] pcm_left_i,
    input  wire logic [23:0] pcm_right_i,
    input  wire logic        pcm_valid_i,
    output logic             pcm_ready_o,
    input  wire logic        mono_i,
    input  wire logic        chan_sel_i,
    input  wire logic        round_select_hi_i,
    input  wire logic        round_select_lo_i,
    input  wire logic [2:0]  fs_index_i,
    input  wire logic [3:0]  low_fs_code_i,
    input  wire logic        validity_i,
    input  wire logic        copy_ok_i,
    input  wire logic [7:0]  user_byte_i,
    input  wire logic        user_strobe_i,
    input  wire logic        i2s_en_i,
    input  wire logic        spdif_en_i,
    output logic             sck_o,
    output logic             sd_o,
    output logic             ws_o,
    output logic             spdif_o,
    output logic             user_busy_o
);
    // Round to the kept width, saturating at positive full scale
    function automatic sao_pkg::sao_sample_t round_sample(
        input sao_pkg::sao_sample_t s,
        input logic [1:0]            sel
    );
        logic [23:0] mask;
        logic [23:0] half;
        logic [24:0] sum;
        mask = `SAO_RND_MASK16;
        half = `SAO_RND_HALF16;
        case (sao_pkg::sao_rnd_t'(sel))
            sao_pkg::RND_18:
            begin
                mask = `SAO_RND_MASK18;
                half = `SAO_RND_HALF18;
            end
            sao_pkg::RND_20:
            begin
                mask = `SAO_RND_MASK20;
                half = `SAO_RND_HALF20;
            end
            sao_pkg::RND_22:
            begin
                mask = `SAO_RND_MASK22;
                half = `SAO_RND_HALF22;
            end
            default:
            begin
                mask = `SAO_RND_MASK16;
                half = `SAO_RND_HALF16;
            end
        endcase
        sum = {s[23], s} + {1'b0, half};
        if (sum[24] != sum[23])
        begin
            round_sample = `SAO_SAT_POS & mask;
        end
        else
        begin
            round_sample = sum[23:0] & mask;
        end
    endfunction : round_sample

    // Channel status bit for a given position in the 192-bit block
    function automatic logic cs_bit(
        input logic [7:0] idx,
        input logic       copy,
        input logic [3:0] code
    );
        cs_bit = 1'b0;
        if (idx == `SAO_CS_COPY)
        begin
            cs_bit = copy;
        end
        else if (idx >= `SAO_CS_FS_LO && idx <= `SAO_CS_FS_HI)
        begin
            cs_bit = code[~idx[1:0]];
        end
    endfunction : cs_bit

    // Link clock synchroniser and edge finder
    logic       lc_s1_q;
    logic       lc_s2_q;
    logic       lc_s3_q;
    logic       lc_lvl_q;
    logic [6:0] cell_q;
    logic [7:0] frame_q;
    logic       i2s_on_q;
    logic       spdif_on_q;
    logic       v_q;
    logic       copy_q;
    logic       par_q;
    logic [8:0] user_sh_q;
    logic [3:0] user_cnt_q;
    sao_pkg::sao_sample_t samp_l_q;
    sao_pkg::sao_sample_t samp_r_q;
    logic [47:0] fifo_data;
    logic        fifo_valid;

    wire tick = (lc_s2_q == lc_s3_q) && lc_s2_q && !lc_lvl_q;
    wire wrap = tick && (cell_q == `SAO_CELLS_LAST);
    wire [6:0] nc   = cell_q + `SAO_CELL_ONE;
    wire       sub  = nc[6];
    wire [4:0] slot = nc[5:1];
    wire       half = nc[0];
    wire [5:0] nb   = nc[6:1];
    wire       i2s_on_nxt   = wrap ? i2s_en_i : i2s_on_q;
    wire       spdif_on_nxt = wrap ? spdif_en_i : spdif_on_q;
    wire [7:0] frame_nxt = (frame_q == `SAO_FRAMES_LAST) ? `SAO_FRAME_FIRST
                                                         : frame_q + `SAO_FRAME_ONE;

    sao_pair_fifo u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .in_data_i   ({pcm_left_i, pcm_right_i}),
        .in_valid_i  (pcm_valid_i),
        .in_ready_o  (pcm_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (wrap)
    );

    // Sample selection: mono or chosen dual channel goes to both sides
    wire [23:0] src_l = fifo_data[47:24];
    wire [23:0] src_r = fifo_data[23:0];
    wire [23:0] pick  = chan_sel_i ? src_r : src_l;
    wire [23:0] use_l = mono_i ? pick : src_l; // RL23
    wire [23:0] use_r = mono_i ? pick : src_r; // RL23
    wire [1:0]  rsel  = {round_select_hi_i, round_select_lo_i};

    // Inter-IC sound: data lags word select by two bits
    wire [5:0] sd_idx = nb - `SAO_I2S_ONE;
    wire [5:0] ws_idx = nb + `SAO_I2S_ONE;
    wire [23:0] sd_smp = sd_idx[5] ? samp_r_q : samp_l_q; // RL2
    wire [4:0]  sd_k   = sd_idx[4:0];
    wire [4:0]  sd_pos = 5'h17 - sd_k;
    wire sd_bit = (sd_k < `SAO_I2S_BITS) ? sd_smp[sd_pos] : 1'b0; // RL3
    wire ws_bit = ws_idx[5]; // RL5

    // Digital audio subframe content
    wire pre_first = wrap ? (frame_nxt == `SAO_FRAME_FIRST) : (frame_q == `SAO_FRAME_FIRST);
    wire [7:0] pre_pat = sub ? `SAO_PRE_W : (pre_first ? `SAO_PRE_B : `SAO_PRE_M); // RL9
    wire [2:0] pre_cell = {slot[1:0], half};
    wire pre_bit = pre_pat[~pre_cell]; // RL8
    wire is_pre = slot < `SAO_PRE_SLOTS;
    wire [23:0] aud_smp = sub ? samp_r_q : samp_l_q;
    wire [4:0]  aud_pos = slot - `SAO_SLOT_AUD;
    wire aud_bit = (slot <= `SAO_SLOT_AUD_END) ? aud_smp[aud_pos] : 1'b0; // RL10
    wire [3:0] fs_code =
        (fs_index_i == sao_pkg::FS_48) ? `SAO_FS_CODE_48 :
        (fs_index_i == sao_pkg::FS_44) ? `SAO_FS_CODE_44 :
        (fs_index_i == sao_pkg::FS_32) ? `SAO_FS_CODE_32 : low_fs_code_i; // RL17 RL18
    wire c_bit = cs_bit(frame_q, copy_q, fs_code); // RL14 RL15 RL16 RL19
    wire u_bit = (user_cnt_q != 4'h0) && user_sh_q[0]; // RL12
    wire d_bit = (slot == `SAO_SLOT_P) ? par_q :  // RL20
                 (slot == `SAO_SLOT_V) ? v_q :    // RL11
                 (slot == `SAO_SLOT_U) ? u_bit :
                 (slot == `SAO_SLOT_C) ? c_bit : aud_bit;
    wire u_take = tick && half && (slot == `SAO_SLOT_U);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            lc_s1_q  <= 1'b0;
            lc_s2_q  <= 1'b0;
            lc_s3_q  <= 1'b0;
            lc_lvl_q <= 1'b0;
        end
        else if (ce_i)
        begin
            lc_s1_q <= cell_clk_i;
            lc_s2_q <= lc_s1_q;
            lc_s3_q <= lc_s2_q;
            if (lc_s2_q == lc_s3_q)
            begin
                lc_lvl_q <= lc_s2_q;
            end
        end
    end

    // Cell and frame counters; enables sampled only at frame edges
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cell_q     <= `SAO_CELLS_LAST;
            frame_q    <= `SAO_FRAMES_LAST;
            i2s_on_q   <= 1'b0;
            spdif_on_q <= 1'b0;
            v_q        <= `SAO_V_RST;
            copy_q     <= `SAO_COPY_RST;
        end
        else if (ce_i)
        begin
            v_q    <= validity_i;  // RL11
            copy_q <= copy_ok_i;   // RL16
            if (tick)
            begin
                cell_q <= nc;      // RL6 RL21
            end
            if (wrap)
            begin
                frame_q    <= frame_nxt; // RL14
                i2s_on_q   <= i2s_en_i;  // RL22
                spdif_on_q <= spdif_en_i;
            end
        end
    end

    // Shared sample register, loaded once per period
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            samp_l_q <= 24'h000000;
            samp_r_q <= 24'h000000;
        end
        else if (ce_i && wrap)
        begin
            samp_l_q <= fifo_valid ? round_sample(use_l, rsel) : 24'h000000; // RL4 RL25
            samp_r_q <= fifo_valid ? round_sample(use_r, rsel) : 24'h000000; // RL4 RL25
        end
    end

    // Inter-IC sound pins
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sck_o <= 1'b0;
            sd_o  <= 1'b0;
            ws_o  <= 1'b0;
        end
        else if (ce_i && tick)
        begin
            if (!i2s_on_nxt)
            begin
                sck_o <= 1'b0; // RL22
                sd_o  <= 1'b0;
                ws_o  <= 1'b0;
            end
            else
            begin
                sck_o <= half; // RL1
                if (!half)
                begin
                    sd_o <= sd_bit; // RL3
                    ws_o <= ws_bit; // RL24
                end
            end
        end
    end

    // Bi-phase mark line and running parity
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            spdif_o <= 1'b0;
            par_q   <= 1'b0;
        end
        else if (ce_i && tick)
        begin
            if (!half && slot >= `SAO_SLOT_AUD && slot != `SAO_SLOT_P)
            begin
                par_q <= (slot == `SAO_SLOT_AUD) ? d_bit : par_q ^ d_bit; // RL20
            end
            if (!spdif_on_nxt)
            begin
                spdif_o <= 1'b0; // RL22
            end
            else if (is_pre)
            begin
                spdif_o <= pre_bit; // RL8
            end
            else if (!half || d_bit)
            begin
                spdif_o <= ~spdif_o; // RL7
            end
        end
    end

    // User byte shifter: start bit then byte, LSB first
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            user_sh_q   <= 9'h000;
            user_cnt_q  <= 4'h0;
            user_busy_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (user_strobe_i && user_cnt_q == 4'h0)
            begin
                user_sh_q   <= {user_byte_i, 1'b1}; // RL12
                user_cnt_q  <= `SAO_USER_BITS;
                user_busy_o <= 1'b1;
            end
            else if (u_take && user_cnt_q != 4'h0)
            begin
                user_sh_q   <= {1'b0, user_sh_q[8:1]};
                user_cnt_q  <= user_cnt_q - `SAO_USER_ONE;
                user_busy_o <= (user_cnt_q != `SAO_USER_ONE);
            end
        end
    end

    // Checks
    logic       sck_prev_q;
    logic [6:0] sck_rise_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sck_prev_q <= 1'b0;
            sck_rise_q <= 7'h00;
        end
        else
        begin
            sck_prev_q <= sck_o;
            sck_rise_q <= wrap ? 7'h00 : sck_rise_q + {6'h00, sck_o & ~sck_prev_q};
        end
    end

    property p_sck_rate;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wrap && i2s_on_q && cell_q == `SAO_CELLS_LAST) |-> sck_rise_q == `SAO_SCK_FRAME;
    endproperty
    a_sck_rate: assert property (p_sck_rate) else $error("bit clock not 64 per frame"); // RL1

    property p_ws_rise;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && $rose(ws_o)) |-> $past(cell_q[6:1]) + `SAO_I2S_ONE == `SAO_WS_RISE;
    endproperty
    a_ws_rise: assert property (p_ws_rise) else $error("word select rose at wrong bit"); // RL24

    property p_ws_fall;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && $fell(ws_o) && i2s_on_q) |-> $past(cell_q[6:1]) + `SAO_I2S_ONE == `SAO_WS_FALL;
    endproperty
    a_ws_fall: assert property (p_ws_fall) else $error("word select fell at wrong bit"); // RL5

    property p_sd_pad;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && tick && !half && i2s_on_nxt && sd_k >= `SAO_I2S_BITS) |=> !sd_o;
    endproperty
    a_sd_pad: assert property (p_sd_pad) else $error("slot padding not zero"); // RL3

    property p_preamble_start;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && tick && spdif_on_nxt && nc[5:0] == `SAO_SUB_START) |=> spdif_o;
    endproperty
    a_preamble_start: assert property (p_preamble_start) else $error("preamble missing"); // RL8

    property p_bmc_edge;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && tick && spdif_on_nxt && !is_pre && !half) |=> spdif_o != $past(spdif_o);
    endproperty
    a_bmc_edge: assert property (p_bmc_edge) else $error("no bit boundary transition"); // RL7

    property p_parity_end;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && tick && spdif_on_q && spdif_on_nxt && nc[5:0] == `SAO_SUB_START) |-> !spdif_o;
    endproperty
    a_parity_end: assert property (p_parity_end) else $error("subframe parity odd"); // RL20

    property p_user_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && user_strobe_i && user_cnt_q == 4'h0) |=> user_cnt_q == `SAO_USER_BITS && user_sh_q[0];
    endproperty
    a_user_load: assert property (p_user_load) else $error("user byte not taken"); // RL12

    property p_block_wrap;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wrap && frame_q == `SAO_FRAMES_LAST) |=> frame_q == `SAO_FRAME_FIRST;
    endproperty
    a_block_wrap: assert property (p_block_wrap) else $error("status block not 192 frames"); // RL14

    property p_sample_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        $changed(samp_l_q) |-> $past(wrap && ce_i);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("sample changed mid period"); // RL25

    property p_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!i2s_on_q && !wrap) ##1 (!i2s_on_q) |-> !sck_o && !ws_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("disabled link toggling"); // RL22
endmodule : sao_serializer

// ==== sim/sao_rx_model.sv ====
// Far-side receiver model: inter-IC sound words and digital audio line cells
module sao_rx_model (
    input  wire logic  clk_i,
    input  wire logic  sck_i,
    input  wire logic  sd_i,
    input  wire logic  ws_i,
    input  wire logic  spdif_i,
    output logic       word_ok_o,
    output logic [31:0] left_o,
    output logic [31:0] right_o,
    output logic [1:0] ws_o,
    output logic       frame_ok_o,
    output logic [127:0] cells_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sck_q = 1'b0;
    logic        ws_q  = 1'b0;
    logic        go    = 1'b0;
    logic [6:0]  c     = 7'h00;
    logic [31:0] sh;
    // Cell position follows clock toggles and is realigned when word select falls
    always @(posedge clk_i)
    begin
        word_ok_o <= 1'b0;
        frame_ok_o <= 1'b0;
        sck_q <= sck_i;
        if (sck_i != sck_q)
        begin
            c = (ws_q && !ws_i) ? 7'h7e : c + 7'h01;
            ws_q = ws_i;
            if (c == 7'h7f)
            begin
                frame_ok_o <= 1'b1;
                go <= 1'b1;
            end
            if (sck_i)
            begin
                sh = {sh[30:0], sd_i};
                if (c == 7'h03) ws_o[1] <= ws_i;
                if (c == 7'h43) ws_o[0] <= ws_i;
                if (c == 7'h41) left_o <= sh;
                if (c == 7'h01)
                begin
                    right_o <= sh;
                    word_ok_o <= go;
                end
            end
        end
        // Line level is captured every cycle, so the first cell after reset is seen
        cells_o[c] <= spdif_i;
    end
endmodule : sao_rx_model

// ==== sim/tb_sao_serializer.sv ====
// Self-checking bench for the audio output serializer
module tb_sao_serializer;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_i = 1'b0, rst_n_i = 1'b0, cell_clk_i, pcm_valid_i = 1'b0;
    logic [23:0]  pcm_left_i = 24'h0, pcm_right_i = 24'h0;
    logic         mono_i = 1'b0, chan_sel_i = 1'b0, validity_i, copy_ok_i;
    logic         round_select_hi_i = 1'b0, round_select_lo_i = 1'b0;
    logic [2:0]   fs_index_i;
    logic [3:0]   low_fs_code_i;
    logic [7:0]   user_byte_i = 8'h00;
    logic         user_strobe_i = 1'b0, i2s_en_i = 1'b1, spdif_en_i = 1'b1;
    logic         pcm_ready_o, sck_o, sd_o, ws_o, spdif_o, user_busy_o;
    logic         word_ok, frame_ok, quiet;
    logic [31:0]  rx_l, rx_r, sf;
    logic [1:0]   rx_ws;
    logic [127:0] cells;
    logic [47:0]  exq[$];
    logic [7:0]   uq[$];
    logic [23:0]  aud_l, aud_r;
    logic [7:0]   ub;
    int           fail_count = 0, tests_run = 0, cyc = 0, fidx = 0, ucnt = 0;

    sao_serializer sao_serializer_i (.clk_i, .rst_n_i, .ce_i(1'b1), .cell_clk_i,
        .pcm_left_i, .pcm_right_i, .pcm_valid_i, .pcm_ready_o, .mono_i, .chan_sel_i,
        .round_select_hi_i, .round_select_lo_i, .fs_index_i, .low_fs_code_i,
        .validity_i, .copy_ok_i, .user_byte_i, .user_strobe_i, .i2s_en_i,
        .spdif_en_i, .sck_o, .sd_o, .ws_o, .spdif_o, .user_busy_o);
    sao_rx_model sao_rx_model_i (.clk_i(clk_i), .sck_i(sck_o), .sd_i(sd_o),
        .ws_i(ws_o), .spdif_i(spdif_o), .word_ok_o(word_ok), .left_o(rx_l),
        .right_o(rx_r), .ws_o(rx_ws), .frame_ok_o(frame_ok), .cells_o(cells));

    always #5 clk_i = ~clk_i;
    initial
    begin
        cell_clk_i = 1'b0;
        #3;
        forever #40 cell_clk_i = ~cell_clk_i;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    function automatic logic [23:0] rnd(input logic [23:0] s, input logic [1:0] sel);
        logic [23:0] sum;
        sum = s + (24'h000080 >> (2 * sel));
        if (!s[23] && sum[23]) sum = 24'h7fffff;
        return sum & (24'hffffff << (8 - 2 * sel));
    endfunction : rnd

    function automatic logic [23:0] nz(input logic [31:0] x);
        return {x[23], ~x[23], x[21:0]};
    endfunction : nz

    function automatic logic cs_bit(input int n);
        logic [3:0] code;
        code = (fs_index_i == 3'h0) ? 4'h4 : (fs_index_i == 3'h1) ? 4'h0 :
               (fs_index_i == 3'h2) ? 4'hc : low_fs_code_i;
        if (n == 2) return copy_ok_i;
        if (n >= 24 && n <= 27) return code[27 - n];
        return 1'b0;
    endfunction : cs_bit

    task automatic push(input logic [23:0] l, input logic [23:0] r);
        logic [1:0] sel;
        sel = {round_select_hi_i, round_select_lo_i};
        pcm_left_i <= l;
        pcm_right_i <= r;
        pcm_valid_i <= 1'b1;
        @(negedge clk_i);
        for (int i = 0; i < 3000 && pcm_ready_o !== 1'b1; i++) @(negedge clk_i);
        @(posedge clk_i);
        exq.push_back({rnd((mono_i && chan_sel_i) ? r : l, sel),
                       rnd((mono_i && !chan_sel_i) ? l : r, sel)});
    endtask : push

    // Decode one subframe of captured line cells
    task automatic sub(input int s);
        logic [7:0] pre;
        logic       bmc;
        int         b;
        b = 64 * s;
        bmc = 1'b1;
        for (int i = 0; i < 8; i++) pre[7 - i] = cells[b + i];
        for (int k = 4; k < 32; k++)
        begin
            sf[k] = cells[b + 2 * k] ^ cells[b + 2 * k + 1];
            bmc &= cells[b + 2 * k] != cells[b + 2 * k - 1];
        end
        check(pre, s ? 8'he4 : (fidx % 192 == 0) ? 8'he8 : 8'he2);
        check(bmc, 1'b1);
        check(^sf[31:4], 1'b0);
        check({sf[28], sf[30]}, {validity_i, cs_bit(fidx % 192)});
        if (s == 1) aud_r = sf[27:4];
        else aud_l = sf[27:4];
        if (ucnt == 0) ucnt = sf[29] ? 8 : 0;
        else
        begin
            ub = {sf[29], ub[7:1]};
            ucnt--;
            if (ucnt == 0)
            begin
                check(ub, uq.size() ? uq[0] : 8'hxx);
                if (uq.size()) uq.delete(0);
            end
        end
    endtask : sub

    always @(negedge clk_i)
    begin
        if (frame_ok)
        begin
            sub(0);
            sub(1);
            fidx++;
        end
        if (word_ok && {rx_l, rx_r} != 64'h0)
        begin
            check({rx_l, rx_r}, exq.size() ? {exq[0][47:24], 8'h00, exq[0][23:0], 8'h00}
                : 64'hx);
            if (exq.size()) exq.delete(0);
            check({rx_l[31:8], rx_r[31:8]}, {aud_l, aud_r});
            check(rx_ws, 2'b01);
        end
    end

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 99000)
        begin
            fail_count++;
            $display("MISMATCH t=%0t run did not complete", $time);
            summarize();
        end
    end

    initial
    begin
        void'($urandom(32'hb92ed1ad));
        fs_index_i = 3'($urandom % 6);
        low_fs_code_i = 4'($urandom);
        validity_i = 1'($urandom);
        copy_ok_i = 1'($urandom);
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        check({pcm_ready_o, sck_o, sd_o, ws_o, spdif_o, user_busy_o}, 6'h20);
        for (int ph = 0; ph < 4; ph++)
        begin
            @(posedge clk_i);
            {round_select_hi_i, round_select_lo_i} <= 2'(ph);
            mono_i <= ph[0];
            chan_sel_i <= ph[1];
            user_byte_i <= 8'($urandom);
            user_strobe_i <= 1'b1;
            @(posedge clk_i);
            user_strobe_i <= 1'b0;
            uq.push_back(user_byte_i);
            @(negedge clk_i);
            check(user_busy_o, 1'b1);
            @(posedge clk_i);
            user_byte_i <= ~user_byte_i;
            user_strobe_i <= 1'b1;
            @(posedge clk_i);
            user_strobe_i <= 1'b0;
            push(24'h7fffff, 24'h800000);
            push(nz($urandom), nz($urandom));
            @(negedge clk_i);
            check(pcm_ready_o, 1'b0);
            for (int i = 0; i < 6; i++) push(nz($urandom), nz($urandom));
            pcm_valid_i <= 1'b0;
            for (int i = 0; i < 20000 && (exq.size() || user_busy_o); i++) @(posedge clk_i);
            repeat (4700) @(posedge clk_i);
        end
        i2s_en_i <= 1'b0;
        spdif_en_i <= 1'b0;
        repeat (2100) @(posedge clk_i);
        quiet = 1'b1;
        for (int i = 0; i < 1100; i++)
        begin
            @(negedge clk_i);
            quiet &= ({sck_o, sd_o, ws_o, spdif_o} === 4'h0);
        end
        check(quiet, 1'b1);
        check(uq.size() + exq.size(), 0);
        summarize();
    end
endmodule : tb_sao_serializer
